/* File: design/emcfg_pkg.sv */
// Package for the emulation-mode configuration block: field positions, encodings, reset values.
// Assumes a single 20 MHz clock domain and a serial register port outside this block.
package emcfg_pkg;
   localparam int EMCFG_EN_BIT = 7;
   localparam int EMCFG_MOD_BIT = 6;
   localparam int EMCFG_PWR_HI = 5;
   localparam int EMCFG_PWR_LO = 4;
   localparam int EMCFG_DEV_BIT = 3;
   localparam int EMCFG_FRQ_HI = 2;
   localparam int EMCFG_FRQ_LO = 0;
   localparam int EMCFG_CAP_HI = 4;
   localparam int EMCFG_CAP_LO = 0;
   localparam logic [7:0] EMCFG_EMU_RESET = 8'h00;
   localparam logic [7:0] EMCFG_PRI_RESET = 8'h00;
   localparam logic [4:0] EMCFG_CAP_MAX = 5'h1f;
   localparam logic [2:0] EMCFG_FRQ_SERIAL = 3'h0;
   // Divide ratios in units of 1/100000, codes 1..7
   localparam logic [23:0] EMCFG_RATIO_1 = 24'h1e0a6e; // 19.68750
   localparam logic [23:0] EMCFG_RATIO_2 = 24'h295a6d; // 27.10125
   localparam logic [23:0] EMCFG_RATIO_3 = 24'h25317c; // 24.37500
   localparam logic [23:0] EMCFG_RATIO_4 = 24'h27dd14; // 26.12500
   localparam logic [23:0] EMCFG_RATIO_5 = 24'h237a08; // 23.25000
   localparam logic [23:0] EMCFG_RATIO_6 = 24'h20e6da; // 21.56250
   localparam logic [23:0] EMCFG_RATIO_7 = 24'h2961c0; // 27.12000

   typedef enum logic [1:0] {EMCFG_SRC_SERIAL, EMCFG_SRC_EMU, EMCFG_SRC_MANUAL} emcfg_src_t;

   typedef struct packed {
      logic fsk;
      logic [1:0] pwr;
      logic hdev;
      logic [2:0] frq;
   } emcfg_tx_t;

   typedef struct packed {
      logic enable;
      logic din;
   } emcfg_pulse_t;
endpackage : emcfg_pkg

/* File: design/emcfg_capcnt.sv */
// Pulse counter for the matching-capacitor value loaded over the data-input pin.
// Assumes pin inputs already synchronous to mclk.
`timescale 1ns/1ns
module emcfg_capcnt
   import emcfg_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire emcfg_pulse_t pins,
   input wire logic [2:0] frq_sel,
   output logic [4:0] cap_val,
   output logic [2:0] cap_frq,
   output logic cap_valid
);
   logic din_q;
   logic en_q;
   logic first_q;
   logic [4:0] cnt_q;
   logic [2:0] frq_q;
   wire din_rise = pins.din & ~din_q;
   wire en_rise = pins.enable & ~en_q;
   wire count_pulse = din_rise & ~pins.enable;

   always_ff @(posedge mclk) begin
      if (reset) begin
         din_q <= 1'b0;
         // Enable idles high; a low value here would fake a rising edge
         en_q <= 1'b1;
         first_q <= 1'b1;
         cnt_q <= 5'h00;
         frq_q <= 3'h0;
         cap_val <= 5'h00;
         cap_frq <= 3'h0;
         cap_valid <= 1'b0;
      end else begin
         din_q <= pins.din;
         en_q <= pins.enable;
         if (count_pulse && first_q) begin
            // First pulse clears the count and latches the frequency
            cnt_q <= 5'h00;
            frq_q <= frq_sel;
            first_q <= 1'b0;
         end else if (count_pulse && cnt_q != EMCFG_CAP_MAX) begin
            // Saturates: extra pulses past 32 total are dropped
            cnt_q <= cnt_q + 5'h01;
         end
         if (en_rise && !first_q) begin
            cap_val <= cnt_q;
            cap_frq <= frq_q;
            cap_valid <= 1'b1;
         end
         // Rearm after each commit so the next burst opens with a clearing pulse
         if (en_rise) begin
            first_q <= 1'b1;
         end
      end
   end

   cap_commit_a: assert property (@(posedge mclk) disable iff (reset)
      (en_rise && !first_q) |=> (cap_val == $past(cnt_q)) && cap_valid)
      else $error("capacitor count not committed on enable rise");
   cap_sat_a: assert property (@(posedge mclk) disable iff (reset)
      (cnt_q == EMCFG_CAP_MAX) |=> (cnt_q == EMCFG_CAP_MAX) || $past(first_q))
      else $error("capacitor counter wrapped");
   cap_first_a: assert property (@(posedge mclk) disable iff (reset)
      (count_pulse && first_q) |=> (cnt_q == 5'h00) && (frq_q == $past(frq_sel)))
      else $error("first pulse did not clear and latch");
endmodule : emcfg_capcnt

/* File: design/emcfg_top.sv */
// Emulation-mode configuration logic: register write port, mode selection, capacitor source choice.
// Assumes the serial interface delivers decoded one-cycle write strobes and byte data.
`timescale 1ns/1ns
module emcfg_top
   import emcfg_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic emu_wr,
   input wire logic pri_wr,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] frequency_pins,
   input wire logic modulation_select_pin,
   input wire logic power_select_high_pin,
   input wire logic power_select_low_pin,
   input wire logic deviation_select_pin,
   input wire emcfg_pulse_t pulse_pins,
   input wire emcfg_tx_t serial_cfg,
   input wire logic [23:0] serial_ratio,
   output logic [7:0] emu_rd,
   output logic [7:0] pri_rd,
   output emcfg_src_t cfg_src,
   output logic fsk_sel,
   output logic [1:0] pwr_sel,
   output logic hdev_sel,
   output logic [23:0] div_ratio,
   output logic [4:0] pa_cap
);
   function automatic logic [23:0] emcfg_ratio(input logic [2:0] code);
      case (code)
         3'h1: emcfg_ratio = EMCFG_RATIO_1;
         3'h2: emcfg_ratio = EMCFG_RATIO_2;
         3'h3: emcfg_ratio = EMCFG_RATIO_3;
         3'h4: emcfg_ratio = EMCFG_RATIO_4;
         3'h5: emcfg_ratio = EMCFG_RATIO_5;
         3'h6: emcfg_ratio = EMCFG_RATIO_6;
         3'h7: emcfg_ratio = EMCFG_RATIO_7;
         default: emcfg_ratio = 24'h000000;
      endcase
   endfunction : emcfg_ratio

   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] emu_q;
   logic [7:0] pri_q;
   logic [4:0] pcap_val;
   logic [2:0] pcap_frq;
   logic pcap_valid;
   logic [2:0] cur_frq;

   always_ff @(posedge mclk) begin
      if (reset) begin
         emu_q <= EMCFG_EMU_RESET;
         pri_q <= EMCFG_PRI_RESET;
      end else begin
         if (emu_wr) begin
            emu_q <= wr_data;
         end
         if (pri_wr) begin
            pri_q <= wr_data;
         end
      end
   end

   emcfg_capcnt u_capcnt (
      .mclk(mclk),
      .reset(reset),
      .pins(pulse_pins),
      .frq_sel(cur_frq),
      .cap_val(pcap_val),
      .cap_frq(pcap_frq),
      .cap_valid(pcap_valid)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Any high frequency pin means manual mode, which outranks the register
   wire manual = |frequency_pins;
   wire emu_on = !manual && emu_q[EMCFG_EN_BIT];
   wire [4:0] reg_cap = pri_q[EMCFG_CAP_HI:EMCFG_CAP_LO];
   emcfg_tx_t emu_cfg;
   assign emu_cfg.fsk = emu_q[EMCFG_MOD_BIT];
   assign emu_cfg.pwr = emu_q[EMCFG_PWR_HI:EMCFG_PWR_LO];
   assign emu_cfg.hdev = emu_q[EMCFG_DEV_BIT];
   assign emu_cfg.frq = emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO];
   emcfg_tx_t pin_cfg;
   assign pin_cfg.fsk = modulation_select_pin;
   assign pin_cfg.pwr = {power_select_high_pin, power_select_low_pin};
   assign pin_cfg.hdev = deviation_select_pin;
   assign pin_cfg.frq = frequency_pins;
   // Emulation takes its fields from its own register; serial_cfg is bypassed, but code zero still uses serial_ratio
   wire emcfg_tx_t sel_cfg = manual ? pin_cfg : (emu_on ? emu_cfg : serial_cfg);
   assign cur_frq = sel_cfg.frq;
   wire preset = manual || (emu_on && emu_cfg.frq != EMCFG_FRQ_SERIAL);
   wire [23:0] ratio_d = preset ? emcfg_ratio(sel_cfg.frq) : serial_ratio;
   // Pulse value belongs to the pin and emulation modes; the full serial set has its own
   wire pulse_hit = pcap_valid && (pcap_frq == cur_frq) && (manual || emu_on);
   // Register capacitor wins whenever nonzero
   wire [4:0] cap_d = (reg_cap != 5'h00) ? reg_cap : (pulse_hit ? pcap_val : 5'h00);
   wire emcfg_src_t src_d = manual ? EMCFG_SRC_MANUAL : (emu_on ? EMCFG_SRC_EMU : EMCFG_SRC_SERIAL);

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (reset) begin
         emu_rd <= EMCFG_EMU_RESET;
         pri_rd <= EMCFG_PRI_RESET;
         cfg_src <= EMCFG_SRC_SERIAL;
         fsk_sel <= 1'b0;
         pwr_sel <= 2'h0;
         hdev_sel <= 1'b0;
         div_ratio <= 24'h000000;
         pa_cap <= 5'h00;
      end else begin
         emu_rd <= emu_q;
         pri_rd <= pri_q;
         cfg_src <= src_d;
         fsk_sel <= sel_cfg.fsk;
         pwr_sel <= sel_cfg.pwr;
         hdev_sel <= sel_cfg.hdev;
         div_ratio <= ratio_d;
         pa_cap <= cap_d;
      end
   end

   emu_enter_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_q[EMCFG_EN_BIT] && frequency_pins == 3'h0) |=> cfg_src == EMCFG_SRC_EMU)
      else $error("emulation mode not entered");
   mod_follow_a: assert property (@(posedge mclk) disable iff (reset)
      emu_on |=> fsk_sel == $past(emu_q[EMCFG_MOD_BIT]))
      else $error("modulation bit not applied");
   pwr_follow_a: assert property (@(posedge mclk) disable iff (reset)
      emu_on |=> pwr_sel == $past(emu_q[EMCFG_PWR_HI:EMCFG_PWR_LO]))
      else $error("power field not applied");
   dev_follow_a: assert property (@(posedge mclk) disable iff (reset)
      emu_on |=> hdev_sel == $past(emu_q[EMCFG_DEV_BIT]))
      else $error("deviation bit not applied");
   ratio_top_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h7) |=> div_ratio == EMCFG_RATIO_7)
      else $error("preset ratio wrong");
   cap_reg_a: assert property (@(posedge mclk) disable iff (reset)
      (pri_q[EMCFG_CAP_HI:EMCFG_CAP_LO] != 5'h00) |=> pa_cap == $past(pri_q[EMCFG_CAP_HI:EMCFG_CAP_LO]))
      else $error("register capacitor not preferred");
   serial_pass_a: assert property (@(posedge mclk) disable iff (reset)
      (!emu_q[EMCFG_EN_BIT] && frequency_pins == 3'h0) |=> div_ratio == $past(serial_ratio))
      else $error("serial settings not used");
   cap_hold_a: assert property (@(posedge mclk) disable iff (reset)
      (pri_q[EMCFG_CAP_HI:EMCFG_CAP_LO] == 5'h00 && !pcap_valid) |=> pa_cap == 5'h00)
      else $error("capacitor nonzero without source");

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes land at the strobe edge and read back one edge later
   emu_write_a: assert property (@(posedge mclk) disable iff (reset)
      emu_wr |=> emu_q == $past(wr_data))
      else $error("emulation register write lost");
   emu_read_a: assert property (@(posedge mclk) disable iff (reset)
      emu_wr |-> ##2 emu_rd == $past(wr_data, 2))
      else $error("emulation register readback wrong");
   pri_write_a: assert property (@(posedge mclk) disable iff (reset)
      pri_wr |=> pri_q == $past(wr_data))
      else $error("primary register write lost");
   pri_read_a: assert property (@(posedge mclk) disable iff (reset)
      pri_wr |-> ##2 pri_rd == $past(wr_data, 2))
      else $error("primary register readback wrong");
   // Manual pins outrank the register, and the same fields then follow the pins
   manual_src_a: assert property (@(posedge mclk) disable iff (reset)
      manual |=> cfg_src == EMCFG_SRC_MANUAL)
      else $error("manual mode not selected");
   manual_mod_a: assert property (@(posedge mclk) disable iff (reset)
      manual |=> fsk_sel == $past(modulation_select_pin))
      else $error("modulation pin not applied");
   manual_pwr_a: assert property (@(posedge mclk) disable iff (reset)
      manual |=> pwr_sel == $past({power_select_high_pin, power_select_low_pin}))
      else $error("power pins not applied");
   manual_dev_a: assert property (@(posedge mclk) disable iff (reset)
      manual |=> hdev_sel == $past(deviation_select_pin))
      else $error("deviation pin not applied");
   manual_ratio_a: assert property (@(posedge mclk) disable iff (reset)
      (frequency_pins == 3'h6) |=> div_ratio == EMCFG_RATIO_6)
      else $error("manual preset ratio wrong");
   // Preset codes 1 to 6, and code zero falling back to the serial ratio
   emu_serial_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == EMCFG_FRQ_SERIAL) |=> div_ratio == $past(serial_ratio))
      else $error("code zero did not use serial ratio");
   ratio_one_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h1) |=> div_ratio == EMCFG_RATIO_1)
      else $error("preset ratio one wrong");
   ratio_two_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h2) |=> div_ratio == EMCFG_RATIO_2)
      else $error("preset ratio two wrong");
   ratio_three_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h3) |=> div_ratio == EMCFG_RATIO_3)
      else $error("preset ratio three wrong");
   ratio_four_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h4) |=> div_ratio == EMCFG_RATIO_4)
      else $error("preset ratio four wrong");
   ratio_five_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h5) |=> div_ratio == EMCFG_RATIO_5)
      else $error("preset ratio five wrong");
   ratio_six_a: assert property (@(posedge mclk) disable iff (reset)
      (emu_on && emu_q[EMCFG_FRQ_HI:EMCFG_FRQ_LO] == 3'h6) |=> div_ratio == EMCFG_RATIO_6)
      else $error("preset ratio six wrong");
   // Serial set and capacitor source when no register value is in force
   serial_cfg_a: assert property (@(posedge mclk) disable iff (reset)
      (!manual && !emu_on) |=>
         {fsk_sel, pwr_sel, hdev_sel} == $past({serial_cfg.fsk, serial_cfg.pwr, serial_cfg.hdev}))
      else $error("serial settings not applied");
   cap_pulse_a: assert property (@(posedge mclk) disable iff (reset)
      (reg_cap == 5'h00 && pulse_hit) |=> pa_cap == $past(pcap_val))
      else $error("pulse capacitor not applied");
   cap_none_a: assert property (@(posedge mclk) disable iff (reset)
      (reg_cap == 5'h00 && !pulse_hit) |=> pa_cap == 5'h00)
      else $error("capacitor applied to wrong frequency");
endmodule : emcfg_top

/* File: verification/emcfg_host.sv */
// Host model for the capacitor pulse protocol on the enable and data-input pins.
// Assumes mclk is the block clock; pins change just after its rising edge.
`timescale 1ns/1ns
module emcfg_host
   import emcfg_pkg::*;
(
   input wire logic mclk,
   output emcfg_pulse_t pins
);
   initial pins = '{enable: 1'b1, din: 1'b0};
   ////////////////////////////////////////////////////////////////////////////
   // Wide pulses keep every din edge clear of the enable edges
   task automatic send_pulses(input int n);
      @(posedge mclk) pins.enable <= 1'b0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk) pins.din <= 1'b1;
         repeat (2) @(posedge mclk);
         pins.din <= 1'b0;
         @(posedge mclk);
      end
      @(posedge mclk) pins.enable <= 1'b1;
      @(posedge mclk);
   endtask : send_pulses
endmodule : emcfg_host

/* File: verification/tb.sv */
// Testbench for the emulation-mode configuration block.
// Assumes one 20 MHz clock; outputs settle one cycle after a register write lands.
`timescale 1ns/1ns
module tb
   import emcfg_pkg::*;
;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic emu_wr = 1'b0;
   logic pri_wr = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic [2:0] frequency_pins = 3'h0;
   logic mod_pin = 1'b1;
   logic pwr_hi = 1'b1;
   logic pwr_lo = 1'b0;
   logic dev_pin = 1'b1;
   emcfg_pulse_t pulse_pins;
   emcfg_tx_t serial_cfg = '{fsk: 1'b0, pwr: 2'h1, hdev: 1'b1, frq: 3'h3};
   logic [23:0] serial_ratio = 24'h123456;
   logic [7:0] emu_rd, pri_rd, d;
   emcfg_src_t cfg_src;
   logic fsk_sel, hdev_sel;
   logic [1:0] pwr_sel;
   logic [23:0] div_ratio;
   logic [4:0] pa_cap;
   logic [23:0] rt [0:7];
   int miscompares = 0;
   int checks_done = 0;
   always #25 mclk = ~mclk;
   emcfg_host host_u (.mclk(mclk), .pins(pulse_pins));
   emcfg_top dut_u (.mclk(mclk), .reset(reset), .emu_wr(emu_wr), .pri_wr(pri_wr), .wr_data(wr_data),
      .frequency_pins(frequency_pins), .modulation_select_pin(mod_pin), .power_select_high_pin(pwr_hi),
      .power_select_low_pin(pwr_lo), .deviation_select_pin(dev_pin), .pulse_pins(pulse_pins),
      .serial_cfg(serial_cfg), .serial_ratio(serial_ratio), .emu_rd(emu_rd), .pri_rd(pri_rd),
      .cfg_src(cfg_src), .fsk_sel(fsk_sel), .pwr_sel(pwr_sel), .hdev_sel(hdev_sel), .div_ratio(div_ratio),
      .pa_cap(pa_cap));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic outs(input logic [1:0] s, input logic f, input logic [1:0] p, input logic h, input logic [23:0] r);
      chk("cfg_src", {22'h0, s}, {22'h0, cfg_src});
      chk("fsk_sel", {23'h0, f}, {23'h0, fsk_sel});
      chk("pwr_sel", {22'h0, p}, {22'h0, pwr_sel});
      chk("hdev_sel", {23'h0, h}, {23'h0, hdev_sel});
      chk("div_ratio", r, div_ratio);
   endtask : outs
   // Ends one cycle after the register update, where the outputs have settled
   task automatic wr(input logic pri, input logic [7:0] v);
      @(posedge mclk);
      emu_wr <= ~pri;
      pri_wr <= pri;
      wr_data <= v;
      @(posedge mclk);
      emu_wr <= 1'b0;
      pri_wr <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : wr
   task automatic settle_cap(input logic [4:0] c);
      repeat (3) @(posedge mclk);
      #1;
      chk("pa_cap", {19'h0, c}, {19'h0, pa_cap});
   endtask : settle_cap
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #3000000;
      miscompares++;
      end_sim();
   end
   initial begin
      rt = '{24'h123456, EMCFG_RATIO_1, EMCFG_RATIO_2, EMCFG_RATIO_3, EMCFG_RATIO_4, EMCFG_RATIO_5,
         EMCFG_RATIO_6, EMCFG_RATIO_7};
      repeat (8) @(posedge mclk);
      #1;
      outs(2'h0, 1'b0, 2'h0, 1'b0, 24'h0);
      chk("emu_rd", {16'h0, EMCFG_EMU_RESET}, {16'h0, emu_rd});
      @(posedge mclk) reset <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      outs(EMCFG_SRC_SERIAL, 1'b0, 2'h1, 1'b1, 24'h123456);
      for (int i = 0; i < 8; i++) begin
         d = {1'b1, i[0], ~i[2:1], i[1], i[2:0]};
         wr(1'b0, d);
         outs(EMCFG_SRC_EMU, d[6], d[5:4], d[3], rt[i]);
         chk("emu_rd", {16'h0, d}, {16'h0, emu_rd});
      end
      wr(1'b0, 8'h81);
      host_u.send_pulses(11);
      settle_cap(5'h0a);
      wr(1'b0, 8'h87);
      settle_cap(5'h00);
      wr(1'b0, 8'h81);
      settle_cap(5'h0a);
      wr(1'b1, 8'h05);
      settle_cap(5'h05);
      chk("pri_rd", 24'h05, {16'h0, pri_rd});
      wr(1'b1, 8'h00);
      settle_cap(5'h0a);
      // Over-long burst: the count stops at the field's top value, latched for code 7
      wr(1'b0, 8'h87);
      host_u.send_pulses(40);
      settle_cap(EMCFG_CAP_MAX);
      wr(1'b0, 8'h81);
      settle_cap(5'h00);
      @(posedge mclk) frequency_pins <= 3'h6;
      repeat (3) @(posedge mclk);
      #1;
      outs(EMCFG_SRC_MANUAL, 1'b1, 2'h2, 1'b1, rt[6]);
      @(posedge mclk) frequency_pins <= 3'h0;
      wr(1'b0, 8'h7f);
      outs(EMCFG_SRC_SERIAL, 1'b0, 2'h1, 1'b1, 24'h123456);
      end_sim();
   end
endmodule : tb
